// *** inc/pss_pkg.sv ***
package pss_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] PSS_CTRL_OFS      = 12'h000;
  localparam logic [11:0] PSS_STAT_OFS      = 12'h004;

  // Field positions in system_control_reg
  localparam int          PSS_EXIT_BIT      = 1;
  localparam int          PSS_DEEP_BIT      = 2;
  localparam int          PSS_PEND_BIT      = 4;

  // Field positions in the status register
  localparam int          PSS_ST_SLEEP_BIT  = 0;
  localparam int          PSS_ST_DEEP_BIT   = 1;
  localparam int          PSS_ST_EVT_BIT    = 2;
  localparam int          PSS_ST_HOLD_BIT   = 3;

  // Reset values
  localparam logic [31:0] PSS_CTRL_RST      = 32'h0000_0000;
  localparam logic        PSS_EVT_RST       = 1'b0;

  // AHB transfer type and response codes
  localparam logic [1:0]  PSS_HTRANS_NONSEQ = 2'h2;
  localparam logic        PSS_HRESP_OKAY    = 1'b0;

  // Sleep state machine, one-hot
  typedef enum logic [2:0] {
    PSS_RUN       = 3'h1,
    PSS_SLEEP_IRQ = 3'h2,
    PSS_SLEEP_EVT = 3'h4
  } pss_state_e;

  // Software controls held in system_control_reg
  typedef struct packed {
    logic evt_on_pend;
    logic deep_sel;
    logic exit_sleep;
  } pss_ctrl_s;

  // Requests to the system clock controller
  typedef struct packed {
    logic core_clk_en;
    logic sys_clk_en;
    logic pll_pd_req;
    logic flash_pd_req;
    logic sleeping;
    logic sleep_deep;
  } pss_clk_s;

endpackage : pss_pkg

// *** hdl/pss_event_latch.sv ***
`timescale 1ns/100ps
module pss_event_latch
  import pss_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_send,
  input  wire logic set_pend,
  input  wire logic consume,
  output logic      evt_latch
);

  logic evt_reg;

  // One-bit event latch, not visible on the bus; a set beats a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_reg <= PSS_EVT_RST;
    end else if (set_send || set_pend) begin
      evt_reg <= 1'b1;
    end else if (consume) begin
      evt_reg <= 1'b0;
    end
  end

  assign evt_latch = evt_reg;

  property p_evt_set;
    @(posedge hclk) disable iff (!hresetn)
    (set_send || set_pend) |=> evt_latch;
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event latch missed a set");

endmodule : pss_event_latch

// *** hdl/pss_sleep_ctrl.sv ***
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// What this block does
// - Light sleep gates only the core clock
// - Deep sleep stops system clock, powers down PLL, flash
// - Deep select bit picks deep over light sleep
// - Wait-for-interrupt sleeps unless wake already pending
// - Wait-for-event sleeps when event latch is clear and no wake pending
// - Wait-for-event with latch set clears it, continues
// - Event latch has no software access path
// - Send-event sets the event latch
// - Sleep-on-exit sleeps on return to thread mode
// - Interrupt-sleep wakes only on enterable exception or debug
// - Priority mask set, fault mask clear holds entry
// - Held-off interrupt wakes core, handler waits for mask
// - Event-sleep wakes on enterable exception
// - Event-on-pend turns any new pend into an event
// - Debug may wake the core at any time
module pss_sleep_ctrl
  import pss_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              wait_irq_exec,
  input  wire logic              wait_evt_exec,
  input  wire logic              send_evt_exec,
  input  wire logic              exit_to_thread,
  input  wire logic              irq_entry_ok,
  input  wire logic              irq_new_pend,
  input  wire logic              debug_wake,
  input  wire logic              priority_mask,
  input  wire logic              fault_mask_a,
  output pss_clk_s               clk_req,
  output logic                   core_halt,
  output logic                   handler_hold
);

  pss_state_e  state_reg;
  pss_state_e  state_next;
  pss_ctrl_s   ctrl_reg;
  pss_clk_s    clk_reg;
  pss_clk_s    clk_next;
  logic        evt_latch;
  logic        evt_consume;
  logic        wake_irq;
  logic        wake_evt;
  logic        go_sleep_irq;
  logic        go_sleep_evt;
  logic        addr_ok;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rd_reg;
  logic [11:0] addr_lo;
  logic        hold_comb;

  // Pick the word address of a byte address
  function automatic logic [11:0] pss_word(input logic [ADDR_W-1:0] a);
    logic [11:0] w;
    w = 12'h000;
    w = {a[11:2], 2'b00};
    return w;
  endfunction : pss_word

  assign addr_lo = pss_word(haddr);

  // ---------------- AHB-Lite slave ----------------

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = PSS_HRESP_OKAY;
  assign addr_ok   = hsel && hready && htrans[1];

  // Capture write address phase for use in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= addr_lo;
      end
    end
  end

  // system_control_reg; the event latch has no address at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= pss_ctrl_s'(PSS_CTRL_RST[2:0]);
    end else if (wr_pend_reg && wr_addr_reg == PSS_CTRL_OFS) begin
      ctrl_reg.exit_sleep  <= hwdata[PSS_EXIT_BIT];
      ctrl_reg.deep_sel    <= hwdata[PSS_DEEP_BIT];
      ctrl_reg.evt_on_pend <= hwdata[PSS_PEND_BIT];
    end
  end

  // Read data launched at the address phase, unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_reg <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rd_reg <= 32'h0000_0000;
      case (addr_lo)
        PSS_CTRL_OFS: begin
          rd_reg[PSS_EXIT_BIT] <= ctrl_reg.exit_sleep;
          rd_reg[PSS_DEEP_BIT] <= ctrl_reg.deep_sel;
          rd_reg[PSS_PEND_BIT] <= ctrl_reg.evt_on_pend;
        end
        PSS_STAT_OFS: begin
          rd_reg[PSS_ST_SLEEP_BIT] <= clk_reg.sleeping;
          rd_reg[PSS_ST_DEEP_BIT]  <= clk_reg.sleep_deep;
          rd_reg[PSS_ST_EVT_BIT]   <= (state_reg == PSS_SLEEP_EVT);
          rd_reg[PSS_ST_HOLD_BIT]  <= hold_comb;
        end
        default: begin
          rd_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign hrdata = rd_reg;

  // ---------------- Sleep control ----------------

  // Wake sources for each kind of sleep
  assign wake_irq = irq_entry_ok || debug_wake;
  assign wake_evt = irq_entry_ok || debug_wake || evt_latch;

  // Entry requests while running
  assign go_sleep_irq = (wait_irq_exec && !wake_irq)
                     || (exit_to_thread && ctrl_reg.exit_sleep && !wake_irq);
  assign go_sleep_evt = wait_evt_exec && !evt_latch && !irq_entry_ok && !debug_wake;

  // Latch consumed by a skipped wait-for-event or by an event wake
  assign evt_consume = (state_reg == PSS_RUN && wait_evt_exec && evt_latch)
                    || (state_reg == PSS_SLEEP_EVT && wake_evt);

  pss_event_latch u_evt (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set_send  (send_evt_exec),
    .set_pend  (irq_new_pend && ctrl_reg.evt_on_pend),
    .consume   (evt_consume),
    .evt_latch (evt_latch)
  );

  // Next state of the sleep machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSS_RUN: begin
        if (go_sleep_irq) begin
          state_next = PSS_SLEEP_IRQ;
        end else if (go_sleep_evt) begin
          state_next = PSS_SLEEP_EVT;
        end
      end
      PSS_SLEEP_IRQ: begin
        if (wake_irq) begin
          state_next = PSS_RUN;
        end
      end
      PSS_SLEEP_EVT: begin
        if (wake_evt) begin
          state_next = PSS_RUN;
        end
      end
      default: begin
        state_next = PSS_RUN;
      end
    endcase
  end

  // State register, reset leaves the core running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= PSS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Clock requests follow the next state so they change with it
  always_comb begin
    clk_next = clk_reg;
    if (state_next == PSS_RUN) begin
      clk_next.core_clk_en  = 1'b1;
      clk_next.sys_clk_en   = 1'b1;
      clk_next.pll_pd_req   = 1'b0;
      clk_next.flash_pd_req = 1'b0;
      clk_next.sleeping     = 1'b0;
      clk_next.sleep_deep   = 1'b0;
    end else if (state_reg == PSS_RUN) begin
      clk_next.sleeping     = 1'b1;
      clk_next.sleep_deep   = ctrl_reg.deep_sel;
      clk_next.core_clk_en  = 1'b0;
      clk_next.sys_clk_en   = !ctrl_reg.deep_sel;
      clk_next.pll_pd_req   = ctrl_reg.deep_sel;
      clk_next.flash_pd_req = ctrl_reg.deep_sel;
    end
  end

  // Clock request flops, frozen for the whole sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_reg <= '{core_clk_en: 1'b1, sys_clk_en: 1'b1, pll_pd_req: 1'b0,
                   flash_pd_req: 1'b0, sleeping: 1'b0, sleep_deep: 1'b0};
    end else begin
      clk_reg <= clk_next;
    end
  end

  assign clk_req   = clk_reg;
  assign core_halt = clk_reg.sleeping;

  // Handler entry held off while the priority mask alone blocks it
  assign hold_comb = irq_entry_ok && priority_mask && !fault_mask_a;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      handler_hold <= 1'b0;
    end else begin
      handler_hold <= hold_comb;
    end
  end

  // ---------------- Checks ----------------

  property p_light;
    @(posedge hclk) disable iff (!hresetn)
    (clk_req.sleeping && !clk_req.sleep_deep) |-> (!clk_req.core_clk_en && clk_req.sys_clk_en
                                                   && !clk_req.pll_pd_req);
  endproperty
  a_light: assert property (p_light) else $error("light sleep clocks wrong");

  property p_deep;
    @(posedge hclk) disable iff (!hresetn)
    (clk_req.sleeping && clk_req.sleep_deep) |-> (!clk_req.sys_clk_en && clk_req.pll_pd_req
                                                  && clk_req.flash_pd_req);
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep requests wrong");

  property p_select;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_RUN && wait_irq_exec && !wake_irq) |=>
      (clk_req.sleeping && clk_req.sleep_deep == $past(ctrl_reg.deep_sel));
  endproperty
  a_select: assert property (p_select) else $error("sleep depth not as selected");

  property p_irq_skip;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_RUN && wait_irq_exec && irq_entry_ok) |=> !core_halt;
  endproperty
  a_irq_skip: assert property (p_irq_skip) else $error("slept despite pending wake");

  property p_evt_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_RUN && wait_evt_exec && !evt_latch && !irq_entry_ok && !debug_wake
     && !wait_irq_exec && !exit_to_thread) |=> (core_halt && state_reg == PSS_SLEEP_EVT);
  endproperty
  a_evt_sleep: assert property (p_evt_sleep) else $error("event wait did not sleep");

  property p_evt_skip;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_RUN && wait_evt_exec && evt_latch && !wait_irq_exec && !exit_to_thread && !send_evt_exec
     && !(irq_new_pend && ctrl_reg.evt_on_pend)) |=> (!core_halt && !evt_latch);
  endproperty
  a_evt_skip: assert property (p_evt_skip) else $error("set latch not consumed");

  property p_exit;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_RUN && exit_to_thread && ctrl_reg.exit_sleep && !wake_irq) |=>
      (core_halt && state_reg == PSS_SLEEP_IRQ);
  endproperty
  a_exit: assert property (p_exit) else $error("no sleep on exit");

  property p_irq_stay;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_SLEEP_IRQ && !irq_entry_ok && !debug_wake) |=> core_halt;
  endproperty
  a_irq_stay: assert property (p_irq_stay) else $error("woke without cause");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    (irq_entry_ok && priority_mask && !fault_mask_a) ##1 (irq_entry_ok && priority_mask)
      |-> handler_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("handler entry not held");

  property p_evt_wake;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_SLEEP_EVT && irq_entry_ok) |=> !core_halt;
  endproperty
  a_evt_wake: assert property (p_evt_wake) else $error("no wake on exception");

  property p_pend_wake;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_SLEEP_EVT && irq_new_pend && ctrl_reg.evt_on_pend) |-> ##[1:2] !core_halt;
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("no wake on new pend");

  property p_dbg;
    @(posedge hclk) disable iff (!hresetn)
    (core_halt && debug_wake) |=> !core_halt;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug did not wake");

  property p_stable;
    @(posedge hclk) disable iff (!hresetn)
    (core_halt && $past(core_halt)) |-> ($stable(clk_req.sleep_deep) && $stable(clk_req.sys_clk_en));
  endproperty
  a_stable: assert property (p_stable) else $error("sleep outputs moved");

  // An enterable exception or debug wake brings the clock enables and sleep flags back to run values one edge later
  property p_drop;
    @(posedge hclk) disable iff (!hresetn)
    (core_halt && (irq_entry_ok || debug_wake)) |=> (clk_req.core_clk_en && clk_req.sys_clk_en
                                                     && !clk_req.sleeping && !clk_req.sleep_deep);
  endproperty
  a_drop: assert property (p_drop) else $error("sleep outputs held after wake");

  // No hold-off unless the priority mask alone blocks an enterable exception
  property p_hold_off;
    @(posedge hclk) disable iff (!hresetn)
    (!priority_mask || fault_mask_a || !irq_entry_ok) |=> !handler_hold;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("handler held without cause");

  // A latched event ends an event sleep and is used up by it
  property p_latch_wake;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == PSS_SLEEP_EVT && evt_latch && !send_evt_exec && !(irq_new_pend && ctrl_reg.evt_on_pend))
      |=> (!core_halt && !evt_latch);
  endproperty
  a_latch_wake: assert property (p_latch_wake) else $error("latched event did not wake");

endmodule : pss_sleep_ctrl

// *** verif/pss_nested_interrupt_ctrl_model.sv ***
`timescale 1ns/100ps
module pss_irq_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic irq_req,
  input  wire logic pend_req,
  output logic      irq_entry_ok,
  output logic      irq_new_pend
);
  // Exception level and new-pend pulse, one cycle behind the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_entry_ok <= 1'b0;
      irq_new_pend <= 1'b0;
    end else begin
      irq_entry_ok <= irq_req;
      irq_new_pend <= pend_req;
    end
  end
endmodule : pss_irq_model

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
  import pss_pkg::*;
  localparam logic [5:0] RUN_V   = 6'h30;
  localparam logic [5:0] LIGHT_V = 6'h12;
  localparam logic [5:0] DEEP_V  = 6'h0f;
  // Row: control word, pulses {debug, send, exit, wait_evt, wait_irq}, clock request while asleep
  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0]  op;
    logic [5:0]  exp;
  } pss_row_s;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rdv;
  logic        wait_irq_exec, wait_evt_exec, send_evt_exec, exit_to_thread, debug_wake;
  logic        priority_mask, fault_mask_a, irq_req, pend_req;
  logic        irq_entry_ok, irq_new_pend, core_halt, handler_hold;
  pss_clk_s    clk_req;
  int          n_fail, n_checks;
  pss_row_s    rows [6] = '{'{32'h0, 5'h01, LIGHT_V}, '{32'h4, 5'h01, DEEP_V},
                            '{32'h2, 5'h04, LIGHT_V}, '{32'h0, 5'h04, RUN_V},
                            '{32'h6, 5'h04, DEEP_V}, '{32'h0, 5'h02, LIGHT_V}};

  assign hready = hreadyout;

  pss_sleep_ctrl u_pss_sleep_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .wait_irq_exec, .wait_evt_exec, .send_evt_exec,
    .exit_to_thread, .irq_entry_ok, .irq_new_pend, .debug_wake, .priority_mask, .fault_mask_a, .clk_req,
    .core_halt, .handler_hold);

  pss_irq_model u_pss_irq_model (.hclk, .hresetn, .irq_req, .pend_req, .irq_entry_ok, .irq_new_pend);

  // Free-running 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  // Single word transfer; waits on ready in both phases
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= PSS_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(32'(hresp), 32'(PSS_HRESP_OKAY));
  endtask : bus

  // One-cycle pulses on the core event inputs
  task automatic fire(input logic [4:0] op);
    @(posedge hclk);
    {debug_wake, send_evt_exec, exit_to_thread, wait_evt_exec, wait_irq_exec} <= op;
    @(posedge hclk);
    {debug_wake, send_evt_exec, exit_to_thread, wait_evt_exec, wait_irq_exec} <= 5'h0;
    #1;
  endtask : fire

  task automatic irq_drive(input logic irq, input logic pend);
    @(posedge hclk);
    irq_req <= irq;
    pend_req <= pend;
    @(posedge hclk);
    pend_req <= 1'b0;
    #1;
  endtask : irq_drive

  // Wait for wake, looking just after each edge so the new value has settled
  task automatic awake(input int n);
    for (int k = 0; k < n && core_halt !== 1'b0; k++) begin
      tick(1);
    end
  endtask : awake

  // Hang guard, far beyond the expected run length
  initial begin
    #(100 * 3000);
    n_fail++;
    end_sim();
  end

  initial begin
    {hresetn, hsel, hwrite, irq_req, pend_req, priority_mask, fault_mask_a} = '0;
    {wait_irq_exec, wait_evt_exec, send_evt_exec, exit_to_thread, debug_wake} = '0;
    {haddr, htrans, hwdata} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(32'(clk_req), 32'(RUN_V));
    chk(32'(core_halt), 32'h0);
    // Sleep entry and debug wake per row
    foreach (rows[i]) begin
      bus(1'b1, PSS_CTRL_OFS, rows[i].ctrl, rdv);
      fire(rows[i].op);
      chk(32'(clk_req), 32'(rows[i].exp));
      tick(3);
      chk(32'(clk_req), 32'(rows[i].exp));
      chk(32'(core_halt), 32'(rows[i].exp != RUN_V));
      fire(5'h10);
      chk(32'(clk_req), 32'(RUN_V));
    end
    // Register map, read-only status, unmapped space
    bus(1'b1, PSS_CTRL_OFS, 32'hffff_ffff, rdv);
    bus(1'b0, PSS_CTRL_OFS, 32'h0, rdv);
    chk(rdv, 32'h16);
    bus(1'b1, PSS_STAT_OFS, 32'hffff_ffff, rdv);
    bus(1'b0, PSS_STAT_OFS, 32'h0, rdv);
    chk(rdv, 32'h0);
    bus(1'b0, 12'h100, 32'h0, rdv);
    chk(rdv, 32'h0);
    // Send-event, then wait-for-event twice
    bus(1'b1, PSS_CTRL_OFS, 32'h10, rdv);
    fire(5'h08);
    fire(5'h02);
    chk(32'(clk_req), 32'(RUN_V));
    fire(5'h02);
    chk(32'(clk_req), 32'(LIGHT_V));
    // Status while in event sleep; a new depth waits for the next sleep
    bus(1'b0, PSS_STAT_OFS, 32'h0, rdv);
    chk(rdv, 32'h5);
    bus(1'b1, PSS_CTRL_OFS, 32'h14, rdv);
    chk(32'(clk_req), 32'(LIGHT_V));
    bus(1'b1, PSS_CTRL_OFS, 32'h10, rdv);
    irq_drive(1'b0, 1'b1);
    awake(6);
    chk(32'(clk_req), 32'(RUN_V));
    // Interrupt sleep ignores new pends, wakes on enterable exception
    fire(5'h01);
    irq_drive(1'b0, 1'b1);
    tick(4);
    chk(32'(core_halt), 32'h1);
    @(posedge hclk);
    priority_mask <= 1'b1;
    irq_drive(1'b1, 1'b0);
    awake(6);
    chk(32'(clk_req), 32'(RUN_V));
    chk(32'(handler_hold), 32'h1);
    bus(1'b0, PSS_STAT_OFS, 32'h0, rdv);
    chk(rdv, 32'h8);
    fire(5'h01);
    chk(32'(core_halt), 32'h0);
    @(posedge hclk);
    fault_mask_a <= 1'b1;
    tick(2);
    chk(32'(handler_hold), 32'h0);
    irq_drive(1'b0, 1'b0);
    // Reset in mid-sleep with the latch still set: core runs and the latch is clear
    fire(5'h01);
    chk(32'(core_halt), 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    tick(3);
    chk(32'(clk_req), 32'(RUN_V));
    @(posedge hclk);
    hresetn <= 1'b1;
    tick(2);
    chk(32'(clk_req), 32'(RUN_V));
    fire(5'h02);
    chk(32'(clk_req), 32'(LIGHT_V));
    fire(5'h10);
    chk(32'(clk_req), 32'(RUN_V));
    end_sim();
  end
endmodule : tb
